// file: verilog/sirq_pkg.sv
// Shared constants and types for the interrupt vector and status block.
package sirq_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD      = 4'h0;
  localparam logic [3:0] ADDR_SPEC     = 4'h1;
  localparam logic [3:0] ADDR_VEC_A    = 4'h2;
  localparam logic [3:0] ADDR_VEC_B    = 4'h3;
  localparam logic [3:0] ADDR_VEC_BASE = 4'h4;
  localparam logic [3:0] ADDR_MCTL     = 4'h5;
  localparam logic [3:0] ADDR_STAT     = 4'h6;
  localparam logic [3:0] ADDR_CLR      = 4'h7;
  localparam logic [3:0] ADDR_EN       = 4'h8;
  localparam logic [3:0] ADDR_TXD      = 4'h9;
  localparam logic [3:0] ADDR_RXD      = 4'hA;

  // ---------------------------------------------------------------
  // Command field and codes
  // ---------------------------------------------------------------
  localparam int         CMD_LSB    = 3;
  localparam logic [2:0] CMD_RST_TX = 3'h5;
  localparam logic [2:0] CMD_ERR_RST = 3'h6;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MIE_BIT   = 3;
  localparam int NSRC      = 3;
  localparam int SRC_TX    = 0;
  localparam int SRC_RX    = 1;
  localparam int SRC_SP    = 2;
  localparam int SPEC_RXAV = 0;
  localparam int SPEC_TXE  = 2;
  localparam int SPEC_PAR  = 4;
  localparam int SPEC_OVR  = 5;
  localparam int SPEC_FRM  = 6;
  localparam int VEC_ST_LSB = 4;

  // ---------------------------------------------------------------
  // Vector status codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] ST_NONE  = 3'h0;
  localparam logic [2:0] ST_TX    = 3'h1;
  localparam logic [2:0] ST_RX    = 3'h2;
  localparam logic [2:0] ST_SP    = 3'h3;
  localparam logic [7:0] VEC_RST  = 8'h00;
  localparam logic [7:0] MCTL_RST = 8'h00;
  localparam logic [2:0] EN_RST   = 3'h0;

  typedef enum logic [1:0] {TX_DISARMED, TX_LOADED, TX_ARMED} tx_state_e;

endpackage

// file: verilog/sirq_flags.sv
// Bank of sticky pending flags where a set beats a simultaneous clear.
module sirq_flags #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Flag control
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  // Flag state
  output logic      [N-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          q[i] <= 1'b0;
        end else if (set[i]) begin
          q[i] <= 1'b1;
        end else if (clr[i]) begin
          q[i] <= 1'b0;
        end
      end

      property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
        set[i] |=> q[i];
      endproperty
      a_set_wins: assert property (p_set_wins) // [R14]
        else $error("Pending flag lost a set.");
    end
  endgenerate

endmodule

// file: verilog/sirq_vec_enc.sv
// Priority encoder that turns pending sources into the vector status code.
module sirq_vec_enc (
  // Pending sources
  input  wire logic [sirq_pkg::NSRC-1:0] ip,
  // Status code
  output logic      [2:0]                code
);

  // Special conditions outrank received data, which outranks transmit.
  function automatic logic [2:0] prio(input logic [sirq_pkg::NSRC-1:0] p);
    if (p[sirq_pkg::SRC_SP]) begin
      return sirq_pkg::ST_SP;
    end else if (p[sirq_pkg::SRC_RX]) begin
      return sirq_pkg::ST_RX;
    end else if (p[sirq_pkg::SRC_TX]) begin
      return sirq_pkg::ST_TX;
    end
    return sirq_pkg::ST_NONE;
  endfunction

  always_comb begin
    code = prio(ip); // [R6] [R7] [R10]
  end

endmodule

// file: verilog/sirq_vector_status.sv
// Interrupt pending, status vector and master enable logic of the serial channel.
// Summary of operation
// R1: Start with transmit and receive buffers empty.
// R2: No transmit interrupt before first character write.
// R3: Transmit pending set as each character loads. The design does not set it when a new character is written in the same cycle.
// R4: Reset-transmit command clears pending, disarms transmit.
// R5: Channel B vector read includes status bits.
// R6: Status encodes highest-priority pending source.
// R7: After clearing, next pending source is shown.
// R8: Host may loop over vector reads freely.
// R9: Master enable clear forces interrupt output high.
// R10: Bit 4 transmit empty, bit 5 receive.
// R11: Special condition flags readable by host.
// R12: Framing, overrun, parity raise special condition.
// R13: Master enable is bit 3 of control.
// R14: Servicing a source clears its pending flag.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module sirq_vector_status (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // Receive character engine
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_framing_err,
  input  wire logic       rx_parity_err,
  // Transmit character engine
  input  wire logic       tx_shift_ready,
  output logic            tx_load,
  output logic      [7:0] tx_data,
  // Interrupt request
  output logic            irq_output_n
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic acc(input logic stb, input logic [3:0] a,
                               input logic [3:0] off);
    return stb && (a == off);
  endfunction

  logic                     wr_cmd;
  logic                     rst_tx_cmd;
  logic                     err_rst_cmd;
  logic                     wr_txd;
  logic                     rd_rxd;
  logic [sirq_pkg::NSRC-1:0] clr_w;

  assign wr_cmd      = acc(wr_en, addr, sirq_pkg::ADDR_CMD);
  assign rst_tx_cmd  = wr_cmd && (wdata[sirq_pkg::CMD_LSB +: 3] == sirq_pkg::CMD_RST_TX);
  assign err_rst_cmd = wr_cmd && (wdata[sirq_pkg::CMD_LSB +: 3] == sirq_pkg::CMD_ERR_RST);
  assign wr_txd      = acc(wr_en, addr, sirq_pkg::ADDR_TXD);
  assign rd_rxd      = acc(rd_en, addr, sirq_pkg::ADDR_RXD);
  assign clr_w       = acc(wr_en, addr, sirq_pkg::ADDR_CLR) ?
                       wdata[sirq_pkg::NSRC-1:0] : '0;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [7:0]                vec_base_r;
  logic [7:0]                mctl_r;
  logic [sirq_pkg::NSRC-1:0] en_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_base_r <= sirq_pkg::VEC_RST;
    end else if (acc(wr_en, addr, sirq_pkg::ADDR_VEC_BASE)) begin
      vec_base_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mctl_r <= sirq_pkg::MCTL_RST;
    end else if (acc(wr_en, addr, sirq_pkg::ADDR_MCTL)) begin
      mctl_r <= wdata; // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_r <= sirq_pkg::EN_RST;
    end else if (acc(wr_en, addr, sirq_pkg::ADDR_EN)) begin
      en_r <= wdata[sirq_pkg::NSRC-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Transmit holding buffer
  // ---------------------------------------------------------------
  // A disarmed transmitter stays silent until software writes a new
  // character, so a drained message does not keep interrupting.
  sirq_pkg::tx_state_e tx_state_r;
  logic [7:0]          tx_hold_r;
  logic                tx_load_r;
  logic [7:0]          tx_data_r;
  logic                tx_move;
  logic                tx_set;

  assign tx_move = (tx_state_r == sirq_pkg::TX_LOADED) && tx_shift_ready;
  // A refill in the same cycle keeps the buffer full, so no empty event.
  assign tx_set  = tx_move && !wr_txd; // [R2] [R3]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_r <= sirq_pkg::TX_DISARMED; // [R1]
    end else begin
      case (tx_state_r)
        sirq_pkg::TX_DISARMED: begin
          if (wr_txd) begin
            tx_state_r <= sirq_pkg::TX_LOADED; // [R2]
          end
        end
        sirq_pkg::TX_LOADED: begin
          if (tx_move && !wr_txd) begin
            tx_state_r <= sirq_pkg::TX_ARMED; // [R3]
          end
        end
        sirq_pkg::TX_ARMED: begin
          if (wr_txd) begin
            tx_state_r <= sirq_pkg::TX_LOADED;
          end else if (rst_tx_cmd) begin
            tx_state_r <= sirq_pkg::TX_DISARMED; // [R4]
          end
        end
        default: begin
          tx_state_r <= sirq_pkg::TX_DISARMED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_hold_r <= 8'h00;
    end else if (wr_txd) begin
      tx_hold_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_load_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else begin
      tx_load_r <= tx_move; // [R3]
      if (tx_move) begin
        tx_data_r <= tx_hold_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive buffer and special conditions
  // ---------------------------------------------------------------
  logic       rx_full_r;
  logic [7:0] rx_data_r;
  logic       frm_r;
  logic       par_r;
  logic       ovr_r;
  logic       ovr_now;
  logic       sp_set;

  assign ovr_now = rx_char_valid && rx_full_r && !rd_rxd;
  assign sp_set  = rx_char_valid && (rx_framing_err || rx_parity_err || ovr_now); // [R12]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_full_r <= 1'b0; // [R1]
    end else if (rx_char_valid) begin
      rx_full_r <= 1'b1;
    end else if (rd_rxd) begin
      rx_full_r <= 1'b0; // [R14]
    end
  end

  // The suspect character is still stored so that software can drain it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data_r <= 8'h00;
    end else if (rx_char_valid) begin
      rx_data_r <= rx_char; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frm_r <= 1'b0;
      par_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      if (rx_char_valid && rx_framing_err) begin
        frm_r <= 1'b1; // [R12]
      end else if (err_rst_cmd) begin
        frm_r <= 1'b0;
      end
      if (rx_char_valid && rx_parity_err) begin
        par_r <= 1'b1; // [R12]
      end else if (err_rst_cmd) begin
        par_r <= 1'b0;
      end
      if (ovr_now) begin
        ovr_r <= 1'b1; // [R12]
      end else if (err_rst_cmd) begin
        ovr_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending flags, priority and interrupt output
  // ---------------------------------------------------------------
  logic [sirq_pkg::NSRC-1:0] set_w;
  logic [sirq_pkg::NSRC-1:0] svc_w;
  logic [sirq_pkg::NSRC-1:0] pend;
  logic [sirq_pkg::NSRC-1:0] ip_w;
  logic [2:0]                st_code;
  logic                      irq_n_r;

  always_comb begin
    set_w                   = '0;
    set_w[sirq_pkg::SRC_TX] = tx_set;
    set_w[sirq_pkg::SRC_RX] = rx_char_valid;
    set_w[sirq_pkg::SRC_SP] = sp_set;
    svc_w                   = clr_w;
    svc_w[sirq_pkg::SRC_TX] = clr_w[sirq_pkg::SRC_TX] || wr_txd || rst_tx_cmd; // [R4] [R14]
    svc_w[sirq_pkg::SRC_RX] = clr_w[sirq_pkg::SRC_RX] || rd_rxd; // [R14]
    svc_w[sirq_pkg::SRC_SP] = clr_w[sirq_pkg::SRC_SP] || err_rst_cmd; // [R14]
  end

  sirq_flags #(
    .N(sirq_pkg::NSRC)
  ) u_flags (
    .clk    (clk),
    .sys_rst(sys_rst),
    .set    (set_w),
    .clr    (svc_w),
    .q      (pend)
  );

  assign ip_w = pend & en_r;

  sirq_vec_enc u_enc (
    .ip  (ip_w),
    .code(st_code)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(mctl_r[sirq_pkg::MIE_BIT] && (|ip_w)); // [R9] [R13]
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] spec_w;
  logic [7:0] vec_b_w;
  logic [7:0] rd_val;
  logic [7:0] rdata_r;

  always_comb begin
    spec_w                     = 8'h00;
    spec_w[sirq_pkg::SPEC_RXAV] = rx_full_r;
    spec_w[sirq_pkg::SPEC_TXE]  = (tx_state_r != sirq_pkg::TX_LOADED); // [R1]
    spec_w[sirq_pkg::SPEC_PAR]  = par_r; // [R11]
    spec_w[sirq_pkg::SPEC_OVR]  = ovr_r; // [R11]
    spec_w[sirq_pkg::SPEC_FRM]  = frm_r; // [R11]
    vec_b_w                                = vec_base_r;
    vec_b_w[sirq_pkg::VEC_ST_LSB +: 3]     = st_code; // [R5] [R6]
  end

  always_comb begin
    case (addr)
      sirq_pkg::ADDR_SPEC:     rd_val = spec_w;
      sirq_pkg::ADDR_VEC_A:    rd_val = vec_base_r;
      sirq_pkg::ADDR_VEC_B:    rd_val = vec_b_w; // [R5]
      sirq_pkg::ADDR_VEC_BASE: rd_val = vec_base_r;
      sirq_pkg::ADDR_MCTL:     rd_val = mctl_r;
      sirq_pkg::ADDR_STAT:     rd_val = {5'h00, pend};
      sirq_pkg::ADDR_EN:       rd_val = {5'h00, en_r};
      sirq_pkg::ADDR_RXD:      rd_val = rx_data_r;
      default:                 rd_val = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (rd_en) begin
      rdata_r <= rd_val;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata        = rdata_r;
  assign tx_load      = tx_load_r;
  assign tx_data      = tx_data_r;
  assign irq_output_n = irq_n_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_reset_empty;
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> !rx_full_r && (tx_state_r == sirq_pkg::TX_DISARMED);
  endproperty
  a_reset_empty: assert property (p_reset_empty) // [R1]
    else $error("Buffers not empty after reset.");

  property p_tx_only_after_write;
    @(posedge clk) disable iff (sys_rst)
    (tx_state_r == sirq_pkg::TX_DISARMED) |-> !pend[sirq_pkg::SRC_TX];
  endproperty
  a_tx_only_after_write: assert property (p_tx_only_after_write) // [R2]
    else $error("Transmit pending raised without a written character.");

  property p_tx_move_pend;
    @(posedge clk) disable iff (sys_rst)
    (tx_move && !wr_txd) |=> tx_load_r && pend[sirq_pkg::SRC_TX]
                             && (tx_state_r == sirq_pkg::TX_ARMED);
  endproperty
  a_tx_move_pend: assert property (p_tx_move_pend) // [R3]
    else $error("Character move did not raise transmit pending.");

  property p_rst_tx;
    @(posedge clk) disable iff (sys_rst)
    (rst_tx_cmd && tx_state_r == sirq_pkg::TX_ARMED)
      |=> !pend[sirq_pkg::SRC_TX] && (tx_state_r == sirq_pkg::TX_DISARMED);
  endproperty
  a_rst_tx: assert property (p_rst_tx) // [R4]
    else $error("Reset transmit command did not disarm.");

  property p_vec_b;
    @(posedge clk) disable iff (sys_rst)
    acc(rd_en, addr, sirq_pkg::ADDR_VEC_B)
      |=> rdata_r[sirq_pkg::VEC_ST_LSB +: 3] == $past(st_code);
  endproperty
  a_vec_b: assert property (p_vec_b) // [R5]
    else $error("Channel B vector lacks status.");

  property p_vec_prio;
    @(posedge clk) disable iff (sys_rst)
    ip_w[sirq_pkg::SRC_SP] |-> st_code == sirq_pkg::ST_SP;
  endproperty
  a_vec_prio: assert property (p_vec_prio) // [R6]
    else $error("Special condition not reported first.");

  sequence s_sp_cleared;
    ip_w[sirq_pkg::SRC_SP] && ip_w[sirq_pkg::SRC_RX] && err_rst_cmd && !rx_char_valid
      && !rd_rxd && !clr_w[sirq_pkg::SRC_RX];
  endsequence
  property p_next_source;
    @(posedge clk) disable iff (sys_rst)
    s_sp_cleared |=> st_code == sirq_pkg::ST_RX;
  endproperty
  a_next_source: assert property (p_next_source) // [R7]
    else $error("Next pending source not shown.");

  sequence s_mie_set;
    !mctl_r[sirq_pkg::MIE_BIT] ##1 mctl_r[sirq_pkg::MIE_BIT] && (|ip_w);
  endsequence
  property p_mie_edge;
    @(posedge clk) disable iff (sys_rst)
    s_mie_set |=> !irq_n_r;
  endproperty
  a_mie_edge: assert property (p_mie_edge) // [R9]
    else $error("Master enable did not reassert interrupt.");

  property p_mie_off;
    @(posedge clk) disable iff (sys_rst)
    !mctl_r[sirq_pkg::MIE_BIT] |=> irq_n_r;
  endproperty
  a_mie_off: assert property (p_mie_off) // [R13]
    else $error("Interrupt active while master enable clear.");

  property p_overrun;
    @(posedge clk) disable iff (sys_rst)
    ovr_now |=> ovr_r && pend[sirq_pkg::SRC_SP];
  endproperty
  a_overrun: assert property (p_overrun) // [R12]
    else $error("Overrun did not raise special condition.");

  property p_rx_read;
    @(posedge clk) disable iff (sys_rst)
    (rd_rxd && !rx_char_valid) |=> !rx_full_r && !pend[sirq_pkg::SRC_RX];
  endproperty
  a_rx_read: assert property (p_rx_read) // [R14]
    else $error("Reading the character did not clear receive.");

endmodule

// file: tb/engine_model.sv
// Behavioural model of the character engines that sit beside the interrupt block.
module engine_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Bench control
  input  wire logic       ready_mode,
  input  wire logic       send,
  input  wire logic [7:0] send_char,
  input  wire logic       send_frm,
  input  wire logic       send_par,
  // Receive engine side
  output logic            rx_char_valid,
  output logic      [7:0] rx_char,
  output logic            rx_framing_err,
  output logic            rx_parity_err,
  // Transmit engine side
  output logic            tx_shift_ready,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_data,
  // Observations
  output logic      [7:0] load_count,
  output logic      [7:0] last_tx
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Receive engine
  // ---------------------------------------------------------------
  // Outside a valid cycle the character toggles, so a design that samples it late is caught.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_char_valid  <= 1'b0;
      rx_char        <= 8'h5A;
      rx_framing_err <= 1'b0;
      rx_parity_err  <= 1'b0;
    end else begin
      rx_char_valid  <= send;
      rx_char        <= send ? send_char : ~rx_char;
      rx_framing_err <= send & send_frm;
      rx_parity_err  <= send & send_par;
    end
  end

  // ---------------------------------------------------------------
  // Transmit engine
  // ---------------------------------------------------------------
  // The engine is busy for one cycle after each load, as a real shifter would be.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_shift_ready <= 1'b0;
      load_count     <= 8'h00;
      last_tx        <= 8'h00;
    end else begin
      tx_shift_ready <= ready_mode & ~tx_load;
      if (tx_load) begin
        load_count <= load_count + 8'h01;
        last_tx    <= tx_data;
      end
    end
  end
endmodule

// file: tb/sirq_vector_status_test.sv
// Self-checking testbench for the interrupt vector and status block.
module sirq_vector_status_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk        = 1'b0;
  logic       sys_rst    = 1'b1;
  logic [3:0] addr       = 4'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr_en      = 1'b0;
  logic       rd_en      = 1'b0;
  logic       ready_mode = 1'b0;
  logic       send       = 1'b0;
  logic [7:0] send_char  = 8'h00;
  logic       send_frm   = 1'b0;
  logic       send_par   = 1'b0;
  logic [7:0] rdata;
  logic       rx_char_valid;
  logic [7:0] rx_char;
  logic       rx_framing_err;
  logic       rx_parity_err;
  logic       tx_shift_ready;
  logic       tx_load;
  logic [7:0] tx_data;
  logic       irq_output_n;
  logic [7:0] load_count;
  logic [7:0] last_tx;
  int         mismatches  = 0;
  int         check_count = 0;

  always #5 clk = ~clk;

  sirq_vector_status u_sirq_vector_status (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_framing_err(rx_framing_err), .rx_parity_err(rx_parity_err),
    .tx_shift_ready(tx_shift_ready), .tx_load(tx_load), .tx_data(tx_data),
    .irq_output_n(irq_output_n)
  );

  engine_model u_engine_model (
    .clk(clk), .sys_rst(sys_rst), .ready_mode(ready_mode), .send(send),
    .send_char(send_char), .send_frm(send_frm), .send_par(send_par),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_framing_err(rx_framing_err),
    .rx_parity_err(rx_parity_err), .tx_shift_ready(tx_shift_ready), .tx_load(tx_load),
    .tx_data(tx_data), .load_count(load_count), .last_tx(last_tx)
  );

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic irq_is(input logic e);
    check({7'h00, irq_output_n}, {7'h00, e});
  endtask

  task automatic rx_send(input logic [7:0] c, input logic f, input logic p);
    @(posedge clk);
    send      <= 1'b1;
    send_char <= c;
    send_frm  <= f;
    send_par  <= p;
    @(posedge clk);
    send <= 1'b0;
    idle(3);
  endtask

  function automatic logic [7:0] vexp(input logic [7:0] base, input logic [2:0] code);
    vexp      = base;
    vexp[6:4] = code;
  endfunction

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  logic [7:0] spec_bit [3] = '{8'h40, 8'h10, 8'h20};

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(sirq_pkg::ADDR_SPEC, 8'h04);
    rdc(sirq_pkg::ADDR_STAT, 8'h00);
    rdc(sirq_pkg::ADDR_VEC_B, 8'h00);
    irq_is(1'b1);
    $display("test reset done");

    ready_mode <= 1'b1;
    wr(sirq_pkg::ADDR_EN, 8'h07);
    wr(sirq_pkg::ADDR_MCTL, 8'h08);
    idle(5);
    rdc(sirq_pkg::ADDR_STAT, 8'h00);
    irq_is(1'b1);
    check(load_count, 8'h00);
    wr(sirq_pkg::ADDR_TXD, 8'h41);
    idle(5);
    check(load_count, 8'h01);
    check(last_tx, 8'h41);
    rdc(sirq_pkg::ADDR_STAT, 8'h01);
    rdc(sirq_pkg::ADDR_VEC_B, vexp(8'h00, sirq_pkg::ST_TX));
    irq_is(1'b0);
    // A stalled engine keeps the second character in the holding buffer.
    ready_mode <= 1'b0;
    wr(sirq_pkg::ADDR_TXD, 8'h42);
    idle(3);
    rdc(sirq_pkg::ADDR_STAT, 8'h00);
    rdc(sirq_pkg::ADDR_SPEC, 8'h00);
    check(load_count, 8'h01);
    ready_mode <= 1'b1;
    idle(5);
    check(load_count, 8'h02);
    check(last_tx, 8'h42);
    rdc(sirq_pkg::ADDR_STAT, 8'h01);
    wr(sirq_pkg::ADDR_CMD, {2'b00, sirq_pkg::CMD_RST_TX, 3'b000});
    idle(8);
    rdc(sirq_pkg::ADDR_STAT, 8'h00);
    irq_is(1'b1);
    check(load_count, 8'h02);
    $display("test transmit done");

    wr(sirq_pkg::ADDR_VEC_BASE, 8'h81);
    rdc(sirq_pkg::ADDR_VEC_A, 8'h81);
    rdc(sirq_pkg::ADDR_VEC_B, 8'h81);
    for (int k = 0; k < 3; k++) begin
      rx_send(8'h50 + 8'(k), k == 0, k == 1);
      if (k == 2)
        rx_send(8'h60, 1'b0, 1'b0);
      rdc(sirq_pkg::ADDR_SPEC, 8'h05 | spec_bit[k]);
      rdc(sirq_pkg::ADDR_VEC_B, vexp(8'h81, sirq_pkg::ST_SP));
      irq_is(1'b0);
      wr(sirq_pkg::ADDR_CMD, {2'b00, sirq_pkg::CMD_ERR_RST, 3'b000});
      rdc(sirq_pkg::ADDR_VEC_B, vexp(8'h81, sirq_pkg::ST_RX));
      if (k < 2)
        rdc(sirq_pkg::ADDR_RXD, 8'h50 + 8'(k));
      else
        wr(sirq_pkg::ADDR_CLR, 8'h02);
      rdc(sirq_pkg::ADDR_VEC_B, 8'h81);
    end
    // The overrun character is still held, so drain it before the next test.
    rdc(sirq_pkg::ADDR_RXD, 8'h60);
    $display("test special done");

    wr(sirq_pkg::ADDR_TXD, 8'h43);
    rx_send(8'h77, 1'b0, 1'b0);
    rdc(sirq_pkg::ADDR_VEC_B, vexp(8'h81, sirq_pkg::ST_RX));
    rdc(sirq_pkg::ADDR_RXD, 8'h77);
    rdc(sirq_pkg::ADDR_VEC_B, vexp(8'h81, sirq_pkg::ST_TX));
    // Dropping master enable and setting it again gives the controller a fresh edge.
    wr(sirq_pkg::ADDR_MCTL, 8'h00);
    idle(2);
    irq_is(1'b1);
    wr(sirq_pkg::ADDR_MCTL, 8'h08);
    idle(2);
    irq_is(1'b0);
    rdc(sirq_pkg::ADDR_MCTL, 8'h08);
    wr(sirq_pkg::ADDR_EN, 8'h06);
    idle(2);
    irq_is(1'b1);
    rdc(sirq_pkg::ADDR_VEC_B, 8'h81);
    wr(sirq_pkg::ADDR_STAT, 8'hFF);
    rdc(sirq_pkg::ADDR_STAT, 8'h01);
    wr(sirq_pkg::ADDR_CLR, 8'h01);
    rdc(sirq_pkg::ADDR_STAT, 8'h00);
    rdc(sirq_pkg::ADDR_CLR, 8'h00);
    rdc(4'hF, 8'h00);
    $display("test enable done");
    report_and_stop();
  end

  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
endmodule
